// ### hdl/cgb_pkg.sv
// Package with constants and types for the clip guard band classifier
package cgb_pkg;
    localparam int CGB_COORD_W = 16;
    localparam int CGB_VIEWS = 16;
    localparam int CGB_SEL_W = 4;
    localparam int CGB_UCF_W = 8;
    localparam int CGB_TOPO_W = 5;
    localparam int CGB_FIFO_DEPTH = 8;
    // Fixed viewport limits in normalized space (signed fixed point, 1.0 = 0x0100)
    localparam logic signed [15:0] CGB_VP_NEG = 16'hFF00;
    localparam logic signed [15:0] CGB_VP_POS = 16'h0100;
    localparam logic signed [15:0] CGB_Z_MIN = 16'h0000;
    localparam logic signed [15:0] CGB_Z_MAX = 16'h0100;
    // Topology codes
    localparam logic [4:0] CGB_TOPO_STRIP = 5'h05;
    localparam logic [4:0] CGB_TOPO_STRIP_REV = 5'h0A;
    localparam logic [4:0] CGB_TOPO_STRIP_ADJ = 5'h0C;
    // Last vertex index per object and guard table word layout
    localparam logic [1:0] CGB_VTX_LAST = 2'h2;
    localparam int CGB_GB_WORD_W = 64;
    typedef enum logic [1:0] {
        CGB_DISCARD = 2'b00,
        CGB_ACCEPT = 2'b01,
        CGB_CLIP = 2'b10
    } cgb_class_t;
    typedef struct packed {
        logic signed [15:0] left_guard_limit;
        logic signed [15:0] right_guard_limit;
        logic signed [15:0] lower_y_guard_limit;
        logic signed [15:0] upper_y_guard_limit;
    } cgb_guard_t;
    // Outcode bit positions
    localparam int OC_VXL = 0;
    localparam int OC_VXR = 1;
    localparam int OC_VYL = 2;
    localparam int OC_VYU = 3;
    localparam int OC_ZL = 4;
    localparam int OC_ZU = 5;
    localparam int OC_GXL = 6;
    localparam int OC_GXR = 7;
    localparam int OC_GYL = 8;
    localparam int OC_GYU = 9;
    localparam int CGB_OC_W = 10;
endpackage : cgb_pkg

// ### hdl/cgb_fifo_if.sv
// Interface carrying the classified object stream into the output FIFO
`timescale 1ns/10ps
interface cgb_fifo_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : cgb_fifo_if

// ### hdl/cgb_fifo.sv
// Parameterised FIFO for classified objects
`timescale 1ns/10ps
module cgb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    cgb_fifo_if.snk wr,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] rp_q, rp_d, wp_q, wp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Handshakes: full and empty from the count
    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = wr.valid && wr.ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rp_q];

    // Next pointers and count
    always_comb begin
        wp_d = push ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d = pop ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register pointers
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end
endmodule : cgb_fifo

// ### hdl/cgb_classifier.sv
// Clip stage object classifier with guard band support
//
// Behaviour
// - Past a viewport side reject, acceptance is judged on the guard band side outcodes.
// - Guard band outcodes are made per vertex only when the guard band test is enabled.
// - Guard band limits are free of the viewport, so a small guard band still gates acceptance.
// - Acceptance also needs every vertex inside the depth planes.
// - Viewport planes use fixed limits; the view selector only picks guard band limits.
// - Sixteen guard band sets sit in memory, found through a base pointer.
// - In screen space the lower Y limit is the top and the upper Y limit the bottom.
// - An accepted object after a discarded one keeps the true strip topology code.
// - Crossing depth or enabled guard planes yields a clip case between discard and accept.
// - With force clip set, user plane discards still occur but crossings become clip cases.
`timescale 1ns/10ps
module cgb_classifier
    import cgb_pkg::*;
#(
    parameter int W = CGB_COORD_W,
    parameter int DEPTH = CGB_FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic VP_SIDE_TEST_EN,
    input wire logic GUARD_TEST_EN,
    input wire logic DEPTH_TEST_EN,
    input wire logic SCREEN_SPACE,
    input wire logic USER_PLANE_FORCE_CLIP,
    input wire logic [CGB_UCF_W-1:0] USER_PLANE_TEST_ENABLES,
    input wire logic [31:0] GUARD_TABLE_BASE,
    output logic [31:0] GUARD_RD_ADDR,
    output logic GUARD_RD_REQ,
    input wire logic GUARD_RD_VALID,
    input wire logic [CGB_GB_WORD_W-1:0] GUARD_RD_DATA,
    input wire logic VTX_VALID,
    output logic VTX_READY,
    input wire logic signed [W-1:0] VTX_X,
    input wire logic signed [W-1:0] VTX_Y,
    input wire logic signed [W-1:0] VTX_Z,
    input wire logic [CGB_UCF_W-1:0] VTX_USER_PLANE_FLAG,
    input wire logic [CGB_SEL_W-1:0] VTX_VIEW_SELECTOR,
    input wire logic [CGB_TOPO_W-1:0] VTX_TOPO,
    input wire logic VTX_STRIP_START,
    output logic OBJ_VALID,
    input wire logic OBJ_READY,
    output logic [1:0] OBJ_CLASS,
    output logic [CGB_TOPO_W-1:0] OBJ_TOPO
);
    typedef enum logic [1:0] {
        CGB_S_FETCH = 2'b00,
        CGB_S_WAIT = 2'b01,
        CGB_S_VERT = 2'b10,
        CGB_S_EMIT = 2'b11
    } cgb_state_t;

    localparam int OW = 2 + CGB_TOPO_W;

    cgb_state_t st_q, st_d;
    cgb_guard_t gb_q, gb_d;
    logic [1:0] vcnt_q, vcnt_d;
    logic [CGB_OC_W-1:0] and_q, and_d, or_q, or_d;
    logic [CGB_UCF_W-1:0] uand_q, uand_d, uor_q, uor_d;
    logic [CGB_TOPO_W-1:0] topo_q, topo_d;
    logic [1:0] cls_q, cls_d;
    logic [CGB_OC_W-1:0] oc;
    logic [CGB_UCF_W-1:0] uoc;
    logic signed [W-1:0] gy_top, gy_bot;
    logic take;
    logic vp_side_rej, user_rej, depth_rej, side_rej, accept, ucf_clip;
    logic [CGB_OC_W-1:0] side_mask, gb_mask;

    cgb_fifo_if #(.W(OW)) fq ();

    // Y limits follow the selected space: screen Y grows downward
    always_comb begin
        if (SCREEN_SPACE) begin
            gy_top = gb_q.lower_y_guard_limit;
            gy_bot = gb_q.upper_y_guard_limit;
        end else begin
            gy_top = gb_q.upper_y_guard_limit;
            gy_bot = gb_q.lower_y_guard_limit;
        end
    end

    // Per-vertex outcodes: viewport on fixed limits, guard band from fetched set
    always_comb begin
        oc = '0;
        oc[OC_VXL] = VP_SIDE_TEST_EN && (VTX_X < CGB_VP_NEG);
        oc[OC_VXR] = VP_SIDE_TEST_EN && (VTX_X > CGB_VP_POS);
        oc[OC_VYL] = VP_SIDE_TEST_EN && (VTX_Y < CGB_VP_NEG);
        oc[OC_VYU] = VP_SIDE_TEST_EN && (VTX_Y > CGB_VP_POS);
        oc[OC_ZL] = DEPTH_TEST_EN && (VTX_Z < CGB_Z_MIN);
        oc[OC_ZU] = DEPTH_TEST_EN && (VTX_Z > CGB_Z_MAX);
        if (GUARD_TEST_EN) begin
            oc[OC_GXL] = VTX_X < gb_q.left_guard_limit;
            oc[OC_GXR] = VTX_X > gb_q.right_guard_limit;
            if (SCREEN_SPACE) begin
                oc[OC_GYL] = VTX_Y < gy_top;
                oc[OC_GYU] = VTX_Y > gy_bot;
            end else begin
                oc[OC_GYL] = VTX_Y < gy_bot;
                oc[OC_GYU] = VTX_Y > gy_top;
            end
        end
        uoc = VTX_USER_PLANE_FLAG & USER_PLANE_TEST_ENABLES;
    end

    assign side_mask = CGB_OC_W'(10'h00F);
    assign gb_mask = CGB_OC_W'(10'h3C0);

    // Object classification from the next accumulated outcodes
    // Reading the next values lets the last vertex of an object count
    always_comb begin
        vp_side_rej = |(and_d & side_mask);
        depth_rej = and_d[OC_ZL] || and_d[OC_ZU];
        user_rej = |uand_d;
        side_rej = vp_side_rej || depth_rej || user_rej;
        ucf_clip = USER_PLANE_FORCE_CLIP && (|uor_d);
        // Guard band replaces viewport sides for acceptance when enabled
        if (GUARD_TEST_EN) begin
            accept = !(|(or_d & gb_mask));
        end else begin
            accept = !(|(or_d & side_mask));
        end
        // User plane crossings alone only block acceptance when force clip is set
        accept = accept && !or_d[OC_ZL] && !or_d[OC_ZU] && !ucf_clip;
        if (side_rej) begin
            cls_d = CGB_DISCARD;
        end else if (accept) begin
            cls_d = CGB_ACCEPT;
        end else begin
            cls_d = CGB_CLIP;
        end
    end

    assign take = (st_q == CGB_S_VERT) && VTX_VALID;
    assign VTX_READY = (st_q == CGB_S_VERT);
    assign GUARD_RD_REQ = (st_q == CGB_S_FETCH);
    // Table entry address: base plus selector times one 8-byte set
    assign GUARD_RD_ADDR = GUARD_TABLE_BASE + {25'h000_0000, VTX_VIEW_SELECTOR, 3'h0};

    // Sequencer: fetch guard set, gather three vertices, emit class
    always_comb begin
        st_d = st_q;
        gb_d = gb_q;
        vcnt_d = vcnt_q;
        and_d = and_q;
        or_d = or_q;
        uand_d = uand_q;
        uor_d = uor_q;
        topo_d = topo_q;
        unique case (st_q)
            CGB_S_FETCH: begin
                if (VTX_VALID) begin
                    st_d = CGB_S_WAIT;
                end
            end
            CGB_S_WAIT: begin
                if (GUARD_RD_VALID) begin
                    gb_d = cgb_guard_t'(GUARD_RD_DATA);
                    st_d = CGB_S_VERT;
                end
            end
            CGB_S_VERT: begin
                if (take) begin
                    if (vcnt_q == '0) begin
                        and_d = oc;
                        or_d = oc;
                        uand_d = uoc;
                        uor_d = uoc;
                        topo_d = VTX_TOPO;
                    end else begin
                        and_d = and_q & oc;
                        or_d = or_q | oc;
                        uand_d = uand_q & uoc;
                        uor_d = uor_q | uoc;
                    end
                    if (vcnt_q == CGB_VTX_LAST) begin
                        vcnt_d = '0;
                        st_d = CGB_S_EMIT;
                    end else begin
                        vcnt_d = vcnt_q + 2'h1;
                    end
                end
            end
            CGB_S_EMIT: begin
                if (fq.ready) begin
                    st_d = CGB_S_FETCH;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_q <= CGB_S_FETCH;
            gb_q <= '0;
            vcnt_q <= '0;
            and_q <= '0;
            or_q <= '0;
            uand_q <= '0;
            uor_q <= '0;
            topo_q <= '0;
            cls_q <= CGB_DISCARD;
        end else begin
            st_q <= st_d;
            gb_q <= gb_d;
            vcnt_q <= vcnt_d;
            and_q <= and_d;
            or_q <= or_d;
            uand_q <= uand_d;
            uor_q <= uor_d;
            topo_q <= topo_d;
            if (st_q == CGB_S_VERT) begin
                cls_q <= cls_d;
            end
        end
    end

    // Push class with the strip's own topology code, never swapped
    assign fq.valid = (st_q == CGB_S_EMIT);
    assign fq.data = {cls_q, topo_q};

    cgb_fifo #(.WIDTH(OW), .DEPTH(DEPTH)) u_fifo (
        .clk(CLK),
        .reset(RESET),
        .wr(fq),
        .out_valid(OBJ_VALID),
        .out_ready(OBJ_READY),
        .out_data({OBJ_CLASS, OBJ_TOPO})
    );

    // Guard assertions
    property p_topo_kept;
        @(posedge CLK) disable iff (RESET)
        (take && vcnt_q == '0) |=> (topo_q == $past(VTX_TOPO));
    endproperty
    a_topo_kept: assert property (p_topo_kept) else $error("topology changed");

    property p_depth_no_accept;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && (or_q[OC_ZL] || or_q[OC_ZU])) |-> cls_q != CGB_ACCEPT;
    endproperty
    a_depth_no_accept: assert property (p_depth_no_accept) else $error("depth accept");

    property p_gb_accept;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && GUARD_TEST_EN && (|(or_q & gb_mask)))
            |-> cls_q != CGB_ACCEPT;
    endproperty
    a_gb_accept: assert property (p_gb_accept) else $error("guard accept");

    property p_vp_nogb;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && !GUARD_TEST_EN && (|(or_q & side_mask)))
            |-> cls_q != CGB_ACCEPT;
    endproperty
    a_vp_nogb: assert property (p_vp_nogb) else $error("side accept");

    property p_gb_off;
        @(posedge CLK) disable iff (RESET)
        !GUARD_TEST_EN |-> (oc & gb_mask) == '0;
    endproperty
    a_gb_off: assert property (p_gb_off) else $error("guard outcode set");

    property p_force_clip;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && USER_PLANE_FORCE_CLIP && (|uor_q)) |-> cls_q != CGB_ACCEPT;
    endproperty
    a_force_clip: assert property (p_force_clip) else $error("user accept");

    property p_user_rej;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && (|uand_q)) |-> cls_q == CGB_DISCARD;
    endproperty
    a_user_rej: assert property (p_user_rej) else $error("user reject lost");

    property p_vp_fixed;
        @(posedge CLK) disable iff (RESET)
        (VP_SIDE_TEST_EN && VTX_X > CGB_VP_POS) |-> oc[OC_VXR];
    endproperty
    a_vp_fixed: assert property (p_vp_fixed) else $error("viewport limit");

    property p_side_discard;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && (|(and_q & side_mask))) |-> cls_q == CGB_DISCARD;
    endproperty
    a_side_discard: assert property (p_side_discard) else $error("side reject lost");

    property p_depth_discard;
        @(posedge CLK) disable iff (RESET)
        (st_q == CGB_S_EMIT && (and_q[OC_ZL] || and_q[OC_ZU])) |-> cls_q == CGB_DISCARD;
    endproperty
    a_depth_discard: assert property (p_depth_discard) else $error("depth reject lost");

    sequence s_fetch;
        st_q == CGB_S_WAIT && GUARD_RD_VALID;
    endsequence
    property p_gb_load;
        @(posedge CLK) disable iff (RESET)
        s_fetch |=> gb_q == $past(GUARD_RD_DATA);
    endproperty
    a_gb_load: assert property (p_gb_load) else $error("guard set not loaded");
endmodule : cgb_classifier

// ### dv/cgb_guard_mem.sv
// Guard band set memory model that answers the classifier's fetches
`timescale 1ns/10ps
module cgb_guard_mem
    import cgb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [31:0] base,
    input wire logic [31:0] rd_addr,
    input wire logic rd_req,
    input wire logic vtx_valid,
    input cgb_guard_t sets [CGB_VIEWS],
    output logic rd_valid,
    output logic [CGB_GB_WORD_W-1:0] rd_data
);
    logic busy_q = 1'b0;
    int wait_q = 0;
    logic [31:0] idx_q = '0;
    initial rd_valid = 1'b0;
    initial rd_data = '0;
    // One answer per fetch; idle data toggles so a stale word never looks valid
    always @(posedge clk) begin
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        if (reset) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            wait_q <= wait_q - 1;
            if (wait_q == 0) begin
                rd_valid <= 1'b1;
                rd_data <= sets[idx_q[3:0]];
                busy_q <= 1'b0;
            end
        end else if (rd_req && vtx_valid) begin
            busy_q <= 1'b1;
            idx_q <= (rd_addr - base) >> 3;
            wait_q <= slow ? int'($urandom % 6) : 0;
        end
    end
endmodule : cgb_guard_mem

// ### dv/test_cgb_classifier.sv
// Self-checking bench for the clip guard band classifier
`timescale 1ns/10ps
module test_cgb_classifier
    import cgb_pkg::*;
;
    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
        logic [7:0] user_plane_flag;
    } cgb_tb_vtx_t;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic vp_en = 0, gb_en = 0, dp_en = 0, scr = 0, frc = 0, slow = 0;
    logic vtx_valid = 0, vtx_ready, strt = 0, obj_valid, obj_ready = 0;
    logic rd_req, rd_valid;
    logic [7:0] ucf_en = '0;
    logic [3:0] vsel = '0;
    logic [4:0] vtopo = '0;
    logic [1:0] obj_class;
    logic [4:0] obj_topo;
    logic [31:0] base = '0, rd_addr;
    logic [63:0] rd_data;
    cgb_tb_vtx_t vtx = '0;
    cgb_guard_t guard_mem [CGB_VIEWS];
    logic [6:0] exp_q [$];
    int n_mismatch = 0, n_tests = 0, cyc = 0, rdy_mode = 1, seed;
    logic signed [15:0] ctab [8] = '{16'hFD00, 16'hFE80, 16'hFF40, 16'hFFC0,
        16'h0040, 16'h00C0, 16'h0180, 16'h0300};
    logic signed [15:0] glim [4] = '{16'h00A0, 16'h0140, 16'h0200, 16'h0280};
    logic [4:0] ttab [3] = '{CGB_TOPO_STRIP, CGB_TOPO_STRIP_REV, CGB_TOPO_STRIP_ADJ};
    localparam int DEPTH_FILL = CGB_FIFO_DEPTH + 1;

    cgb_classifier i_cgb_classifier (.CLK(CLK), .RESET(RESET), .VP_SIDE_TEST_EN(vp_en),
        .GUARD_TEST_EN(gb_en), .DEPTH_TEST_EN(dp_en), .SCREEN_SPACE(scr),
        .USER_PLANE_FORCE_CLIP(frc), .USER_PLANE_TEST_ENABLES(ucf_en),
        .GUARD_TABLE_BASE(base), .GUARD_RD_ADDR(rd_addr), .GUARD_RD_REQ(rd_req),
        .GUARD_RD_VALID(rd_valid), .GUARD_RD_DATA(rd_data), .VTX_VALID(vtx_valid),
        .VTX_READY(vtx_ready), .VTX_X(vtx.x), .VTX_Y(vtx.y), .VTX_Z(vtx.z),
        .VTX_USER_PLANE_FLAG(vtx.user_plane_flag), .VTX_VIEW_SELECTOR(vsel), .VTX_TOPO(vtopo),
        .VTX_STRIP_START(strt), .OBJ_VALID(obj_valid), .OBJ_READY(obj_ready),
        .OBJ_CLASS(obj_class), .OBJ_TOPO(obj_topo));
    cgb_guard_mem i_cgb_guard_mem (.clk(CLK), .reset(RESET), .slow(slow), .base(base),
        .rd_addr(rd_addr), .rd_req(rd_req), .vtx_valid(vtx_valid), .sets(guard_mem),
        .rd_valid(rd_valid), .rd_data(rd_data));

    // Clock, 20 ns period
    always #10 CLK = ~CLK;

    // Downstream ready: held low, random or always high
    always @(posedge CLK) begin
        #1 obj_ready = (rdy_mode == 2) || (rdy_mode == 1 && $urandom % 2);
    end

    // Hang guard
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // Each object leaving the block is matched against the oldest note
    always @(negedge CLK) begin
        if (!RESET && obj_valid === 1'b1 && obj_ready) begin
            check({obj_class, obj_topo}, exp_q.size() ? exp_q.pop_front() : 7'h7F);
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check

    // Class expected from per-vertex outcodes under the current settings
    function automatic logic [1:0] expect_cls(input cgb_tb_vtx_t v [3], input cgb_guard_t g);
        logic [17:0] a, r, o;
        a = '1;
        r = '0;
        for (int i = 0; i < 3; i++) begin
            o[3:0] = {v[i].y > CGB_VP_POS, v[i].y < CGB_VP_NEG, v[i].x > CGB_VP_POS,
                v[i].x < CGB_VP_NEG} & {4{vp_en}};
            o[5:4] = {v[i].z > CGB_Z_MAX, v[i].z < CGB_Z_MIN} & {2{dp_en}};
            o[9:6] = {v[i].y > g.upper_y_guard_limit, v[i].y < g.lower_y_guard_limit,
                v[i].x > g.right_guard_limit, v[i].x < g.left_guard_limit} & {4{gb_en}};
            o[17:10] = v[i].user_plane_flag & ucf_en;
            a &= o;
            r |= o;
        end
        if (|{a[17:10], a[5:0]}) begin
            return CGB_DISCARD;
        end
        if (!(|r[5:4]) && !(gb_en ? |r[9:6] : |r[3:0]) && !(frc && |r[17:10])) begin
            return CGB_ACCEPT;
        end
        return CGB_CLIP;
    endfunction : expect_cls

    // Three vertices of one object; selector held for the whole object
    task automatic send_obj(input bit hold);
        cgb_tb_vtx_t v [3];
        logic [4:0] t;
        int bx, by, bz, ub, n;
        vsel = 4'($urandom);
        t = ttab[$urandom % 3];
        bx = $urandom % 7;
        by = $urandom % 7;
        bz = 3 + $urandom % 3;
        ub = $urandom % 8;
        for (int k = 0; k < 3; k++) begin
            v[k] = {ctab[bx + $urandom % 2], ctab[by + $urandom % 2],
                ctab[bz + $urandom % 2], 8'(($urandom % 2) << ub)};
        end
        for (int k = 0; k < 3; k++) begin
            vtx = v[k];
            vtopo = k ? 5'($urandom) : t;
            strt = (k == 0);
            vtx_valid = 1'b1;
            if (hold && k == 0) begin
                repeat (40) begin
                    @(posedge CLK);
                    #1 check(vtx_ready, 0);
                end
                rdy_mode = 1;
            end
            n = 0;
            while (vtx_ready !== 1'b1 && n < 300) begin
                @(posedge CLK);
                #1 n++;
            end
            check(n < 300, 1);
            @(posedge CLK);
            #1;
        end
        exp_q.push_back({expect_cls(v, guard_mem[vsel]), t});
    endtask : send_obj

    task automatic drain;
        int n;
        vtx_valid = 1'b0;
        for (n = 0; n < 400 && exp_q.size() != 0; n++) begin
            @(posedge CLK);
            #1;
        end
        check(exp_q.size(), 0);
    endtask : drain

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Main sequence: every enable combination, then a full output buffer
    initial begin
        seed = $urandom(32'h0000_EEC6);
        foreach (guard_mem[i]) begin
            guard_mem[i] = {-glim[$urandom % 4], glim[$urandom % 4],
                -glim[$urandom % 4], glim[$urandom % 4]};
        end
        repeat (12) @(posedge CLK);
        #1 RESET = 1'b0;
        check(vtx_ready, 0);
        check(obj_valid, 0);
        check(rd_req, 1);
        for (int c = 0; c < 32; c++) begin
            {slow, frc, dp_en, gb_en, vp_en} = 5'(c);
            scr = $urandom % 2;
            ucf_en = 8'($urandom);
            base = $urandom & 32'hFFFF_FF00;
            rdy_mode = (c % 3) ? 1 : 2;
            repeat (12) send_obj(0);
            drain();
        end
        rdy_mode = 0;
        repeat (DEPTH_FILL) send_obj(0);
        send_obj(1);
        drain();
        stop_test();
    end
endmodule : test_cgb_classifier
